/* File: design/ubt_user_break_unit.sv */
// user break unit: channel matching, sequential chaining, break timing, pc trace
// assumes bus monitor inputs are synchronous one-cycle strobes from the core
//
// Contract
// - data breaks skip excluded cycles
// - address compare width follows access size
// - data channels need both address and data
// - word/byte ignore upper data half
// - pre-exec fetch break saves matched address
// - post-exec fetch break saves next address
// - prohibited positions defer to accepting instruction
// - data breaks taken at next instruction
// - xy bus only on C/D, one bus
// - x uses upper half, y lower
// - mode 01 chains C then D
// - mode 10 chains B, C, D
// - mode 11 chains A, B, C, D
// - simultaneous hits count for earlier first
// - pair hit with pre-exec later breaks
// - execution counts gate chained C/D
// - trace enable starts branch recording
// - dest fetch and last source fetch
// - pointer is half source minus executed
// - delayed 4n+2 case stores destination
// - satisfied condition requests break, sets flag
// - flags sticky, software writes zero
// - four-entry queues shift per branch
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module ubt_user_break_unit #(
    parameter int CNT_W = 12,
    parameter int PTR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ubt_pkg::REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata_q,
    input wire logic bus_valid,
    input wire logic bus_dma,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic bus_excluded,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_data,
    input wire logic xy_valid,
    input wire logic xy_is_y,
    input wire logic xy_write,
    input wire logic [15:0] xy_addr,
    input wire logic [15:0] xy_data,
    input wire logic exec_valid,
    input wire logic exec_int_ok,
    input wire logic [31:0] exec_addr,
    input wire logic branch_valid,
    input wire logic branch_dly_int,
    input wire logic [31:0] branch_src_fetch,
    input wire logic [31:0] pre_branch_addr,
    input wire logic [31:0] branch_dest,
    input wire logic break_ack,
    output logic break_req,
    output logic [31:0] break_pc_q
);
    import ubt_pkg::*;

    localparam int ENT_W = 64 + PTR_W;

    // address compare, low bits dropped by the cycle's own access size
    function automatic logic ubt_addr_ok(input logic [31:0] a, input logic [31:0] ref_a,
                                         input logic [31:0] msk, input logic [1:0] sz);
        logic [31:0] keep;
        keep = (sz == SZ_LONG) ? 32'hFFFFFFFC : (sz == SZ_WORD) ? 32'hFFFFFFFE : 32'hFFFFFFFF;
        return ((a ^ ref_a) & ~msk & keep) == 32'h00000000;
    endfunction : ubt_addr_ok

    // data compare; word and byte never look above bit 15
    function automatic logic ubt_data_ok(input logic [31:0] d, input logic [31:0] ref_d,
                                         input logic [31:0] msk, input logic [1:0] sz);
        logic [31:0] keep;
        keep = (sz == SZ_LONG) ? 32'hFFFFFFFF : (sz == SZ_WORD) ? 32'h0000FFFF :
               (sz == SZ_BYTE) ? 32'h000000FF : 32'h00000000;
        return ((d ^ ref_d) & ~msk & keep) == 32'h00000000;
    endfunction : ubt_data_ok

    logic [CTRL_W-1:0] ctrl_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [31:0] ch_addr_q [NCH];
    logic [31:0] ch_mask_q [NCH];
    logic [7:0] ch_cyc_q [NCH];
    logic [31:0] ch_data_q [NCH];
    logic [31:0] ch_dmask_q [NCH];
    logic [CNT_W-1:0] cnt_q [NCH];
    logic [CNT_W-1:0] remain_q [NCH];
    logic [1:0] stage_q;
    logic [1:0] stage_d;
    ubt_brk_type state_q;
    ubt_brk_type state_d;
    logic [31:0] pc_d;
    logic [ENT_W-1:0] tq_q [TRQ_DEPTH];
    logic [ENT_W-1:0] tq_d [TRQ_DEPTH];
    logic [2:0] tq_cnt_q;
    logic [2:0] tq_cnt_d;
    logic [31:0] rd_mux;

    // register port decode
    logic is_ch;
    logic [1:0] ch_idx;
    logic [4:0] ch_off;
    logic ch_wr;
    logic ctrl_wr;
    logic flag_wr;
    logic [1:0] wr_first;
    assign is_ch = (reg_addr[7:5] >= CH_BLK_LO) && (reg_addr[7:5] <= CH_BLK_HI);
    assign ch_idx = 2'(reg_addr[7:5] - CH_BLK_LO);
    assign ch_off = reg_addr[4:0];
    assign ch_wr = reg_write && is_ch;
    assign ctrl_wr = reg_write && (reg_addr == ADDR_CTRL);
    assign flag_wr = reg_write && (reg_addr == ADDR_FLAGS);
    assign wr_first = 2'(CH_D - {reg_wdata[CTL_SEQ_HI], reg_wdata[CTL_SEQ_LO]});

    // per-channel match results
    logic [NCH-1:0] fetch_hit;
    logic [NCH-1:0] bus_hit;
    logic [NCH-1:0] xy_hit;
    logic [NCH-1:0] raw;
    logic [NCH-1:0] eff;
    logic [NCH-1:0] pre_hit;
    logic [NCH-1:0] cnt_ok;
    logic [NCH-1:0] xy_en_v;
    logic [NCH-1:0] xy_sel_v;
    // only C and D carry the xy bus option
    assign xy_en_v = {ctrl_q[CTL_XYEN_D], ctrl_q[CTL_XYEN_C], 2'b00};
    assign xy_sel_v = {ctrl_q[CTL_XYSEL_D], ctrl_q[CTL_XYSEL_C], 2'b00};

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic [1:0] sz;
        logic [1:0] rw;
        logic [1:0] kind;
        logic [1:0] mst;
        logic en;
        logic has_data;
        logic [15:0] xa;
        logic [15:0] xm;
        logic [15:0] xd;
        logic [15:0] xdm;
        assign sz = ch_cyc_q[g][CYC_SIZE_LSB +: 2];
        assign rw = ch_cyc_q[g][CYC_RW_LSB +: 2];
        assign kind = ch_cyc_q[g][CYC_KIND_LSB +: 2];
        assign mst = ch_cyc_q[g][CYC_MST_LSB +: 2];
        // a 00 read/write, kind or master selection disables the channel outright; size 00 drops the size condition and the data compare
        assign en = (rw != 2'h0) && (kind != 2'h0) && (mst != 2'h0);
        assign has_data = (g >= int'(CH_C));
        // fetch is matched on the execute stream so overrun fetches never break
        assign fetch_hit[g] = en && kind[0] && mst[0] && rw[0] && exec_valid &&
                              ubt_addr_ok(exec_addr, ch_addr_q[g], ch_mask_q[g], SZ_BYTE);
        assign bus_hit[g] = en && !xy_en_v[g] && bus_valid && !bus_excluded && kind[1] &&
                            (bus_dma ? mst[1] : mst[0]) && (bus_write ? rw[1] : rw[0]) &&
                            ((sz == SZ_NONE) || (sz == bus_size)) &&
                            ubt_addr_ok(bus_addr, ch_addr_q[g], ch_mask_q[g], bus_size) &&
                            (!has_data || ubt_data_ok(bus_data, ch_data_q[g], ch_dmask_q[g],
                                                      sz));
        // x takes the upper half of each register, y the lower
        assign xa = xy_sel_v[g] ? ch_addr_q[g][15:0] : ch_addr_q[g][31:16];
        assign xm = xy_sel_v[g] ? ch_mask_q[g][15:0] : ch_mask_q[g][31:16];
        assign xd = xy_sel_v[g] ? ch_data_q[g][15:0] : ch_data_q[g][31:16];
        assign xdm = xy_sel_v[g] ? ch_dmask_q[g][15:0] : ch_dmask_q[g][31:16];
        assign xy_hit[g] = en && xy_en_v[g] && xy_valid && (xy_is_y == xy_sel_v[g]) &&
                           kind[1] && mst[0] && (xy_write ? rw[1] : rw[0]) &&
                           ((sz == SZ_NONE) || (sz == SZ_WORD)) &&
                           (((xy_addr ^ xa) & ~xm) == 16'h0000) &&
                           ubt_data_ok({16'h0000, xy_data}, {16'h0000, xd}, {16'h0000, xdm}, sz);
        assign raw[g] = fetch_hit[g] || bus_hit[g] || xy_hit[g];
        // a zero count means no count condition
        assign cnt_ok[g] = !has_data || (cnt_q[g] == '0) || (remain_q[g] == CNT_W'(1));
        assign eff[g] = raw[g] && cnt_ok[g];
        // pre-exec select bit low means break before execution
        assign pre_hit[g] = fetch_hit[g] && !ctrl_q[CTL_PRE_LSB + g];
    end

    // sequential chain: seq bits 01 start at C, 10 at B, 11 at A
    logic seq_on;
    logic [1:0] seq_first;
    logic [1:0] stage_nxt;
    logic [NCH-1:0] counted;
    logic [NCH-1:0] fire_vec;
    logic pair_fire;
    logic fire;
    logic fire_pre;
    logic [7:0] set_vec;
    assign seq_on = ctrl_q[CTL_SEQ_HI] || ctrl_q[CTL_SEQ_LO];
    assign seq_first = 2'(CH_D - {ctrl_q[CTL_SEQ_HI], ctrl_q[CTL_SEQ_LO]});
    assign stage_nxt = 2'(stage_q + 2'h1);

    // only the expected channel advances, so a joint hit counts for the earlier one
    always_comb begin
        counted = '0;
        fire_vec = '0;
        pair_fire = 1'b0;
        stage_d = stage_q;
        for (int i = 0; i < NCH; i++) begin
            if ((!seq_on || (2'(i) < seq_first)) && eff[i]) begin
                counted[i] = 1'b1;
                fire_vec[i] = 1'b1;
            end
        end
        if (seq_on && eff[stage_q]) begin
            counted[stage_q] = 1'b1;
            if (stage_q == CH_D) begin
                fire_vec[CH_D] = 1'b1;
                stage_d = seq_first;
            end else if (eff[stage_nxt] && pre_hit[stage_nxt]) begin
                counted[stage_nxt] = 1'b1;
                fire_vec[stage_nxt] = 1'b1;
                pair_fire = 1'b1;
                stage_d = seq_first;
            end else begin
                stage_d = stage_nxt;
            end
        end
    end

    assign fire = |fire_vec;
    assign fire_pre = |(fire_vec & pre_hit);
    // low nibble cpu flags, high nibble dma flags
    assign set_vec = {counted & bus_hit & {NCH{bus_dma}}, counted & ~(bus_hit & {NCH{bus_dma}})};
    // a hardware set in the clearing cycle survives the write
    assign flags_d = (flag_wr ? (flags_q & reg_wdata[7:0]) : flags_q) | set_vec;

    // software registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            for (int i = 0; i < NCH; i++) begin
                ch_addr_q[i] <= 32'h00000000;
                ch_mask_q[i] <= 32'h00000000;
                ch_cyc_q[i] <= CYC_RST;
                ch_data_q[i] <= 32'h00000000;
                ch_dmask_q[i] <= 32'h00000000;
                cnt_q[i] <= '0;
            end
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= reg_wdata[CTRL_W-1:0];
            end
            if (ch_wr) begin
                case (ch_off)
                    OFF_ADDR: ch_addr_q[ch_idx] <= reg_wdata;
                    OFF_MASK: ch_mask_q[ch_idx] <= reg_wdata;
                    OFF_CYC: ch_cyc_q[ch_idx] <= reg_wdata[7:0];
                    OFF_DATA: if (ch_idx >= CH_C) ch_data_q[ch_idx] <= reg_wdata;
                    OFF_DMASK: if (ch_idx >= CH_C) ch_dmask_q[ch_idx] <= reg_wdata;
                    OFF_CNT: if (ch_idx >= CH_C) cnt_q[ch_idx] <= reg_wdata[CNT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // execution counters reload after each completed count
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst) begin
                remain_q[i] <= '0;
            end else if (ch_wr && (ch_off == OFF_CNT) && (ch_idx == 2'(i))) begin
                remain_q[i] <= reg_wdata[CNT_W-1:0];
            end else if (raw[i]) begin
                remain_q[i] <= cnt_ok[i] ? cnt_q[i] : CNT_W'(remain_q[i] - CNT_W'(1));
            end
        end
    end

    // flags and chain position
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= FLAGS_RST;
            stage_q <= CH_D;
        end else begin
            flags_q <= flags_d;
            stage_q <= ctrl_wr ? wr_first : stage_d;
        end
    end

    // break timing: pre-exec fetch can go at once, everything else waits for
    // the next instruction that accepts interrupts
    always_comb begin
        state_d = state_q;
        pc_d = break_pc_q;
        case (state_q)
            BRK_IDLE: begin
                if (fire && fire_pre && exec_int_ok) begin
                    state_d = BRK_REQ;
                    pc_d = exec_addr;
                end else if (fire) begin
                    state_d = BRK_WAIT;
                end
            end
            BRK_WAIT: begin
                if (exec_valid && exec_int_ok) begin
                    state_d = BRK_REQ;
                    pc_d = exec_addr;
                end
            end
            BRK_REQ: begin
                if (break_ack) begin
                    state_d = BRK_IDLE;
                end
            end
            default: state_d = BRK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= BRK_IDLE;
            break_pc_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            break_pc_q <= pc_d;
        end
    end

    assign break_req = (state_q == BRK_REQ);

    // pc trace queue: entry is {pointer, source, destination}, head at index 0
    logic push;
    logic pop;
    logic [31:0] new_src;
    logic [31:0] ptr_diff;
    logic [PTR_W-1:0] new_ptr;
    logic [2:0] cnt_tmp;
    logic [ENT_W-1:0] head;
    assign push = branch_valid && ctrl_q[CTL_TRACE_EN];
    // reading the destination entry retires the head
    assign pop = reg_read && (reg_addr == ADDR_TR_DST) && (tq_cnt_q != 3'h0);
    assign new_src = branch_dly_int ? branch_dest : branch_src_fetch;
    assign ptr_diff = branch_src_fetch - pre_branch_addr;
    // pointer has no meaning in the delayed 4n+2 case, stored as zero
    assign new_ptr = branch_dly_int ? '0 : ptr_diff[PTR_W:1];
    assign head = (tq_cnt_q != 3'h0) ? tq_q[0] : '0;

    // a full queue drops its oldest entry rather than the new branch
    always_comb begin
        tq_d = tq_q;
        cnt_tmp = tq_cnt_q;
        if (pop) begin
            for (int i = 0; i < TRQ_DEPTH - 1; i++) begin
                tq_d[i] = tq_q[i + 1];
            end
            cnt_tmp = 3'(tq_cnt_q - 3'h1);
        end
        if (push) begin
            if (cnt_tmp == TRQ_DEPTH) begin
                for (int i = 0; i < TRQ_DEPTH - 1; i++) begin
                    tq_d[i] = tq_d[i + 1];
                end
                tq_d[TRQ_DEPTH - 1] = {new_ptr, new_src, branch_dest};
            end else begin
                tq_d[cnt_tmp[1:0]] = {new_ptr, new_src, branch_dest};
                cnt_tmp = 3'(cnt_tmp + 3'h1);
            end
        end
        tq_cnt_d = cnt_tmp;
    end

    // entries carry no reset, only the fill count does
    always_ff @(posedge clk) begin
        tq_q <= tq_d;
        tq_cnt_q <= rst ? 3'h0 : tq_cnt_d;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (is_ch) begin
            case (ch_off)
                OFF_ADDR: rd_mux = ch_addr_q[ch_idx];
                OFF_MASK: rd_mux = ch_mask_q[ch_idx];
                OFF_CYC: rd_mux = 32'(ch_cyc_q[ch_idx]);
                OFF_DATA: rd_mux = ch_data_q[ch_idx];
                OFF_DMASK: rd_mux = ch_dmask_q[ch_idx];
                OFF_CNT: rd_mux = 32'(cnt_q[ch_idx]);
                default: rd_mux = 32'h00000000;
            endcase
        end else begin
            case (reg_addr)
                ADDR_CTRL: rd_mux = 32'(ctrl_q);
                ADDR_FLAGS: rd_mux = 32'(flags_q);
                ADDR_TR_PTR: rd_mux = 32'(head[ENT_W-1:64]);
                ADDR_TR_SRC: rd_mux = head[63:32];
                ADDR_TR_DST: rd_mux = head[31:0];
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_q <= 32'h00000000;
        end else begin
            reg_rdata_q <= reg_read ? rd_mux : 32'h00000000;
        end
    end

    default clocking ubt_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    flag_sticky_a: assert property (
        !flag_wr |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("match flag dropped without a write");
    flag_set_a: assert property (
        (set_vec != 8'h00) |=> (flags_q & $past(set_vec)) == $past(set_vec))
        else $error("counted match did not set its flag");
    excl_cycle_a: assert property (
        bus_excluded |-> (bus_hit == 4'h0))
        else $error("excluded bus cycle matched");
    seq_order_a: assert property (
        (seq_on && fire_vec[CH_D] && !pair_fire) |-> (stage_q == CH_D))
        else $error("channel D fired out of chain order");
    seq_restart_a: assert property (
        (seq_on && fire && !ctrl_wr && (counted[CH_D] || pair_fire)) |=>
        (stage_q == $past(seq_first)))
        else $error("chain did not restart after break");
    pre_pc_a: assert property (
        (state_q == BRK_IDLE && fire_pre && exec_int_ok) |=>
        (break_req && break_pc_q == $past(exec_addr)))
        else $error("pre-exec break saved wrong pc");
    post_wait_a: assert property (
        (state_q == BRK_IDLE && fire && !fire_pre) |=> (state_q == BRK_WAIT && !break_req))
        else $error("post-exec or data break taken too early");
    wait_pc_a: assert property (
        (state_q == BRK_WAIT && exec_valid && exec_int_ok) |=>
        (break_req && break_pc_q == $past(exec_addr)))
        else $error("deferred break saved wrong pc");
    req_hold_a: assert property (
        (break_req && !break_ack) |=> (break_req && $stable(break_pc_q)))
        else $error("break request dropped before ack");
    trace_push_a: assert property (
        (push && !pop && tq_cnt_q != TRQ_DEPTH) |=> (tq_cnt_q == 3'($past(tq_cnt_q) + 3'h1)))
        else $error("trace queue did not grow on branch");
    trace_src_a: assert property (
        (push && !pop && tq_cnt_q == 3'h0) |=>
        (tq_q[0][63:32] == $past(new_src) && tq_q[0][31:0] == $past(branch_dest)))
        else $error("trace entry holds wrong addresses");

    cover property (seq_on && seq_first == CH_A && fire_vec[CH_D]);
    cover property (pair_fire);
    cover property (push && tq_cnt_q == TRQ_DEPTH);
    cover property (break_req && break_ack);
endmodule : ubt_user_break_unit

/* File: design/ubt_pkg.sv */
// constants for the user break match and trace block
// assumes a plain register port with byte addresses on an 8-bit address
package ubt_pkg;
    // channel indices, A first
    localparam int NCH = 4;
    localparam logic [1:0] CH_A = 2'h0;
    localparam logic [1:0] CH_B = 2'h1;
    localparam logic [1:0] CH_C = 2'h2;
    localparam logic [1:0] CH_D = 2'h3;

    // register port geometry
    localparam int REG_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_TR_PTR = 8'h08;
    localparam logic [7:0] ADDR_TR_SRC = 8'h0C;
    localparam logic [7:0] ADDR_TR_DST = 8'h10;
    // channel blocks sit at 0x20, 0x40, 0x60, 0x80 (block number 1 to 4)
    localparam logic [2:0] CH_BLK_LO = 3'h1;
    localparam logic [2:0] CH_BLK_HI = 3'h4;
    localparam logic [4:0] OFF_ADDR = 5'h00;
    localparam logic [4:0] OFF_MASK = 5'h04;
    localparam logic [4:0] OFF_CYC = 5'h08;
    localparam logic [4:0] OFF_DATA = 5'h0C;
    localparam logic [4:0] OFF_DMASK = 5'h10;
    localparam logic [4:0] OFF_CNT = 5'h14;

    // control register fields
    localparam int CTRL_W = 12;
    localparam int CTL_SEQ_LO = 0;
    localparam int CTL_SEQ_HI = 1;
    localparam int CTL_TRACE_EN = 2;
    localparam int CTL_PRE_LSB = 4;
    localparam int CTL_XYEN_C = 8;
    localparam int CTL_XYEN_D = 9;
    localparam int CTL_XYSEL_C = 10;
    localparam int CTL_XYSEL_D = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

    // cycle register fields, two bits each
    localparam int CYC_SIZE_LSB = 0;
    localparam int CYC_RW_LSB = 2;
    localparam int CYC_KIND_LSB = 4;
    localparam int CYC_MST_LSB = 6;
    localparam logic [7:0] CYC_RST = 8'h00;

    // operand size codes, shared by cycle register and bus
    localparam logic [1:0] SZ_NONE = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    localparam logic [7:0] FLAGS_RST = 8'h00;

    // trace queue
    localparam logic [2:0] TRQ_DEPTH = 3'h4;

    typedef enum logic [2:0] {
        BRK_IDLE = 3'b001,
        BRK_WAIT = 3'b010,
        BRK_REQ = 3'b100
    } ubt_brk_type;
endpackage : ubt_pkg

/* File: sim/ubt_interrupt_ctrl_model.sv */
// interrupt controller stand-in: accepts a pending user break after a delay
// assumes break_req is a level that is held until break_ack is seen
`timescale 1ns/1ps
module ubt_interrupt_ctrl_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic break_req,
    output logic break_ack
);
    logic [3:0] wait_q;
    // count while a request pends; a one-cycle ack, since a level would hide a late drop
    always_ff @(posedge clk) begin
        if (rst || !break_req || break_ack) begin
            wait_q <= 4'h0;
            break_ack <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            break_ack <= (wait_q == 4'(ACK_DLY));
        end
    end
endmodule : ubt_interrupt_ctrl_model

/* File: sim/user_break_match_and_trace_test.sv */
// self-checking bench for the user break unit: data, fetch and trace paths
// assumes the register port answers one cycle after the read strobe
`timescale 1ns/1ps
module user_break_match_and_trace_test;
    import ubt_pkg::*;
    logic clk, rst, reg_write, reg_read, bus_valid, bus_dma, bus_write, bus_excluded;
    logic xy_valid, xy_is_y, xy_write, exec_valid, exec_int_ok, branch_valid, branch_dly_int;
    logic break_ack, break_req;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_q, bus_addr, bus_data, exec_addr, break_pc_q;
    logic [31:0] branch_src_fetch, pre_branch_addr, branch_dest, base, src, pre;
    logic [1:0] bus_size;
    logic [15:0] xy_addr, xy_data, ya, yd;
    logic [7:0] dat;
    int num_errors, n_checks;

    ubt_user_break_unit u_ubt_user_break_unit (.clk, .rst, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata_q, .bus_valid, .bus_dma, .bus_write, .bus_size, .bus_excluded,
        .bus_addr, .bus_data, .xy_valid, .xy_is_y, .xy_write, .xy_addr, .xy_data, .exec_valid,
        .exec_int_ok, .exec_addr, .branch_valid, .branch_dly_int, .branch_src_fetch,
        .pre_branch_addr, .branch_dest, .break_ack, .break_req, .break_pc_q);
    ubt_interrupt_ctrl_model u_ubt_interrupt_ctrl_model (.clk, .rst, .break_req, .break_ack);

    // pointer that lets software rebuild the pre-branch address
    function automatic logic [31:0] ptr_exp(input logic [31:0] s, input logic [31:0] p);
        return ((s - p) >> 1) & 32'h000000FF;
    endfunction : ptr_exp

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // every driver leaves a gap cycle so no strobe is assigned twice in one step
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(nm, exp, reg_rdata_q);
        @(posedge clk);
    endtask : rd
    task bus(input logic [31:0] a, input logic [1:0] sz, input logic ex);
        bus_addr <= a;
        bus_size <= sz;
        bus_excluded <= ex;
        bus_valid <= 1'b1;
        @(posedge clk);
        bus_valid <= 1'b0;
        @(posedge clk);
    endtask : bus
    task exec(input logic [31:0] a);
        exec_addr <= a;
        exec_valid <= 1'b1;
        @(posedge clk);
        exec_valid <= 1'b0;
        @(posedge clk);
    endtask : exec
    // one cpu write on the x (y=0) or y (y=1) memory bus
    task xyb(input logic y, input logic [15:0] a, input logic [15:0] d);
        xy_is_y <= y;
        xy_addr <= a;
        xy_data <= d;
        xy_write <= 1'b1;
        xy_valid <= 1'b1;
        @(posedge clk);
        xy_valid <= 1'b0;
        @(posedge clk);
    endtask : xyb
    // bounded waits for the request and for its drop after the ack
    task wait_brk(input logic [31:0] pc);
        int i;
        for (i = 0; i < 20 && break_req !== 1'b1; i++) begin @(posedge clk); #1; end
        if (i == 20) begin
            num_errors++;
            stop_test();
        end
        chk("break_pc", pc, break_pc_q);
        for (i = 0; i < 20 && break_req !== 1'b0; i++) begin @(posedge clk); #1; end
        if (i == 20) begin
            num_errors++;
            stop_test();
        end
        @(posedge clk);
    endtask : wait_brk
    task stop_test();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        {rst, reg_write, reg_read, bus_valid, bus_dma, bus_write, bus_excluded} = 7'h01 << 6;
        {xy_valid, xy_is_y, xy_write, exec_valid, branch_valid, branch_dly_int} = 6'h00;
        exec_int_ok = 1'b1;
        {reg_addr, reg_wdata, bus_addr, bus_data, exec_addr, bus_size, xy_addr, xy_data} = '0;
        {branch_src_fetch, pre_branch_addr, branch_dest} = '0;
        void'($urandom(80274));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_FLAGS, 32'h0, "flags_reset");
        rd(8'hF0, 32'h0, "unmapped");
        // channel A: cpu data read, no size condition, address low bits 11
        base = $urandom() & 32'hFFFFFFFC;
        wr(8'h20, base | 32'h3);
        wr(8'h28, 32'h64);
        for (int s = 1; s < 4; s++) begin
            bus(base + ((s == 3) ? 0 : 4 - s), 2'(s), 1'b0);
            exec(base ^ 32'h100);
            wait_brk(base ^ 32'h100);
            rd(ADDR_FLAGS, 32'h1, "flag_a");
            wr(ADDR_FLAGS, 32'h0);
            rd(ADDR_FLAGS, 32'h0, "flag_clear");
        end
        bus(base, SZ_WORD, 1'b0);
        bus(base | 32'h3, SZ_LONG, 1'b1);
        rd(ADDR_FLAGS, 32'h0, "no_match");
        // channel B fetch break, pre then post execution
        wr(8'h40, base ^ 32'h40);
        wr(8'h48, 32'h54);
        exec(base ^ 32'h40);
        wait_brk(base ^ 32'h40);
        wr(ADDR_CTRL, 32'h20);
        exec(base ^ 32'h40);
        exec(base ^ 32'h42);
        wait_brk(base ^ 32'h42);
        // two branches into the trace queue, then drain it
        wr(ADDR_CTRL, 32'h4);
        src = $urandom();
        pre = src - 2 * ($urandom() % 100);
        branch_src_fetch <= src;
        pre_branch_addr <= pre;
        branch_dest <= ~src;
        branch_valid <= 1'b1;
        @(posedge clk);
        // back-to-back delayed branch to a 4n+2 target, interrupted before it ran
        branch_dly_int <= 1'b1;
        branch_dest <= {src[31:2], 2'b10};
        @(posedge clk);
        branch_valid <= 1'b0;
        branch_dly_int <= 1'b0;
        @(posedge clk);
        rd(ADDR_TR_PTR, ptr_exp(src, pre), "trace_ptr");
        rd(ADDR_TR_SRC, src, "trace_src");
        rd(ADDR_TR_DST, ~src, "trace_dst");
        rd(ADDR_TR_PTR, 32'h0, "dly_ptr");
        rd(ADDR_TR_SRC, {src[31:2], 2'b10}, "dly_src");
        rd(ADDR_TR_DST, {src[31:2], 2'b10}, "dly_dst");
        rd(ADDR_TR_DST, 32'h0, "trace_empty");
        // channel C byte data read; junk in the upper halves must not matter
        wr(ADDR_FLAGS, 32'h0);
        wr(8'h60, base ^ 32'h1000);
        wr(8'h68, 32'h65);
        dat = 8'($urandom());
        wr(8'h6C, {16'hA5C3, dat, dat});
        wr(8'h70, 32'hFFFF0000);
        bus_data <= {24'h0, ~dat};
        bus(base ^ 32'h1000, SZ_BYTE, 1'b0);
        rd(ADDR_FLAGS, 32'h0, "data_miss");
        bus_data <= {24'($urandom()), dat};
        bus(base ^ 32'h1000, SZ_BYTE, 1'b0);
        rd(ADDR_FLAGS, 32'h4, "data_hit");
        exec(base ^ 32'h200);
        wait_brk(base ^ 32'h200);
        // chain C then D, with D watching y bus writes in the lower halves
        ya = 16'($urandom());
        yd = 16'($urandom());
        wr(ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL, 32'hA01);
        wr(8'h80, {16'($urandom()), ya});
        wr(8'h88, 32'h6A);
        wr(8'h8C, {16'($urandom()), yd});
        xyb(1'b1, ya, yd);
        rd(ADDR_FLAGS, 32'h0, "chain_early");
        bus(base ^ 32'h1000, SZ_BYTE, 1'b0);
        xyb(1'b0, ya, yd);
        rd(ADDR_FLAGS, 32'h4, "chain_c");
        xyb(1'b1, ya, yd);
        exec(base ^ 32'h300);
        wait_brk(base ^ 32'h300);
        rd(ADDR_FLAGS, 32'hC, "chain_cd");
        stop_test();
    end
endmodule : user_break_match_and_trace_test
